// ===== core/internal_oscillator_block.sv
// Chosen here: the strobed register port and the placing of the registers.
module internal_oscillator_block #(
	parameter int TRIM_SETTLE_CYCLES = osc_pkg::TRIM_SETTLE_CYCLES
) (
	input  wire logic       sys_clk_in,                // 20 MHz system clock
	input  wire logic       rst_n_in,                  // synchronous reset, active low
	input  wire logic [3:0] reg_addr_in,               // register address
	input  wire logic [7:0] reg_wdata_in,              // register write data
	input  wire logic       reg_wr_in,                 // write strobe
	input  wire logic       reg_rd_in,                 // read strobe
	output logic      [7:0] reg_rdata_out,             // read data, cycle after strobe
	input  wire logic       fast_osc_clk_in,           // raw fast oscillator output
	input  wire logic       slow_rc_clk_in,            // raw slow RC oscillator output
	output logic            fast_osc_en_out,           // fast oscillator run enable
	output logic            slow_rc_en_out,            // slow RC oscillator run enable
	output logic      [4:0] trim_field_out,            // trim code to fast oscillator
	output logic            pll_enable_out,            // PLL enable
	input  wire logic       pwrt_en_in,                // power-up timer enabled
	input  wire logic       fail_safe_en_in,           // fail-safe clock monitor enabled
	input  wire logic       watchdog_en_in,            // watchdog timer enabled
	input  wire logic       two_speed_en_in,           // two-speed start-up enabled
	input  wire logic [1:0] pin_mode_in,               // oscillator pin mode configuration
	output logic            device_clk_out,            // selected device clock
	input  wire logic       first_osc_pin_in,          // first oscillator pin level
	output logic            first_osc_pin_out,         // first oscillator pin drive value
	output logic            first_osc_pin_oe_out,      // first oscillator pin drive enable
	input  wire logic       second_osc_pin_in,         // second oscillator pin level
	output logic            second_osc_pin_out,        // second oscillator pin drive value
	output logic            second_osc_pin_oe_out,     // second oscillator pin drive enable
	input  wire logic       port_a_bit_seven_data_in,  // port bit seven output latch
	input  wire logic       port_a_bit_seven_drive_in, // port bit seven drive enable
	output logic            port_a_bit_seven_read_out, // port bit seven pin level
	input  wire logic       port_a_bit_six_data_in,    // port bit six output latch
	input  wire logic       port_a_bit_six_drive_in,   // port bit six drive enable
	output logic            port_a_bit_six_read_out    // port bit six pin level
);

	localparam int STEP_CYCLES_RAW = TRIM_SETTLE_CYCLES / osc_pkg::TRIM_LEVELS;
	localparam int STEP_CYCLES     = (STEP_CYCLES_RAW < 1) ? 1 : STEP_CYCLES_RAW;
	localparam logic [15:0] STEP_LAST = 16'(STEP_CYCLES - 1);
	localparam logic [15:0] SETTLE_LIMIT = 16'(TRIM_SETTLE_CYCLES);

	clk_mux_if mux_if ();

	logic [2:0]  freq_sel_r;
	logic [7:0]  trim_reg_r;
	logic [4:0]  trim_cur_r;
	logic [15:0] step_cnt_r;
	logic [7:0]  rdata_r;
	logic        fast_en_r;
	logic        slow_en_r;
	logic        pll_en_r;
	logic [2:0]  fast_sync_r;
	logic [2:0]  slow_sync_r;
	logic [1:0]  first_sync_r;
	logic [1:0]  second_sync_r;
	logic        fosc4_phase_r;
	logic        fosc4_r;
	logic        first_out_r;
	logic        first_oe_r;
	logic        second_out_r;
	logic        second_oe_r;
	logic        ctrl_wr;
	logic        trim_wr;
	logic        internal_mode;
	logic        slow_need;
	logic        fast_need;

	assign ctrl_wr       = reg_wr_in && (reg_addr_in == osc_pkg::CTRL_ADDR);
	assign trim_wr       = reg_wr_in && (reg_addr_in == osc_pkg::TRIM_ADDR);
	assign internal_mode = (pin_mode_in == osc_pkg::PIN_MODE_CLKOUT) || (pin_mode_in == osc_pkg::PIN_MODE_DUAL_IO);

	// register writes
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			freq_sel_r <= osc_pkg::FREQ_SEL_RESET;
		end else if (ctrl_wr) begin
			freq_sel_r <= reg_wdata_in[osc_pkg::CTRL_FREQ_LSB +: 3]; // [RQ7]
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			trim_reg_r <= osc_pkg::TRIM_RESET;
		end else if (trim_wr) begin
			trim_reg_r <= reg_wdata_in & osc_pkg::TRIM_WRITE_MASK; // [RQ10]
		end
	end

	// read data stands only in the cycle after the strobe; unmapped addresses read zero
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			rdata_r <= 8'h00;
		end else if (reg_rd_in) begin
			case (reg_addr_in)
				osc_pkg::CTRL_ADDR: begin
					rdata_r <= {1'b0, freq_sel_r, mux_if.on_fast, slow_en_r, 2'b00};
				end
				osc_pkg::TRIM_ADDR: begin
					rdata_r <= trim_reg_r; // [RQ12]
				end
				default: begin
					rdata_r <= 8'h00;
				end
			endcase
		end else begin
			rdata_r <= 8'h00;
		end
	end

	assign reg_rdata_out = rdata_r;

	// oscillator run enables; the old source runs on until the mux has left it, else a high phase never ends
	assign fast_need = (freq_sel_r != osc_pkg::FREQ_SEL_31K) || trim_reg_r[osc_pkg::TRIM_SLOW_SRC_BIT] // [RQ3] [RQ4]
		|| mux_if.on_fast; // [RQ15]
	assign slow_need = ((freq_sel_r == osc_pkg::FREQ_SEL_31K) && !trim_reg_r[osc_pkg::TRIM_SLOW_SRC_BIT]) // [RQ5]
		|| !mux_if.on_fast // [RQ15]
		|| pwrt_en_in || fail_safe_en_in || watchdog_en_in || two_speed_en_in; // [RQ6] [RQ13]

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			fast_en_r <= 1'b1;
			slow_en_r <= 1'b0;
			pll_en_r  <= 1'b0;
		end else begin
			fast_en_r <= fast_need;
			slow_en_r <= slow_need;
			pll_en_r  <= trim_reg_r[osc_pkg::TRIM_PLL_BIT] && internal_mode; // [RQ14]
		end
	end

	assign fast_osc_en_out = fast_en_r;
	assign slow_rc_en_out  = slow_en_r;
	assign pll_enable_out  = pll_en_r;

	// trim code walks one level per step so a full sweep fits in the settle time
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			step_cnt_r <= 16'h0000;
			trim_cur_r <= osc_pkg::TRIM_RESET[osc_pkg::TRIM_FIELD_MSB:0];
		end else if (step_cnt_r >= STEP_LAST) begin
			step_cnt_r <= 16'h0000;
			if (trim_cur_r < trim_reg_r[osc_pkg::TRIM_FIELD_MSB:0]) begin
				trim_cur_r <= 5'(trim_cur_r + 5'h01); // [RQ11]
			end else if (trim_cur_r > trim_reg_r[osc_pkg::TRIM_FIELD_MSB:0]) begin
				trim_cur_r <= 5'(trim_cur_r - 5'h01); // [RQ11]
			end
		end else begin
			step_cnt_r <= 16'(step_cnt_r + 16'h0001);
		end
	end

	assign trim_field_out = trim_cur_r; // [RQ10]

	// oscillator outputs are asynchronous; third stage only feeds the edge detect
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			fast_sync_r <= 3'h0;
			slow_sync_r <= 3'h0;
		end else begin
			fast_sync_r <= {fast_sync_r[1:0], fast_osc_clk_in};
			slow_sync_r <= {slow_sync_r[1:0], slow_rc_clk_in};
		end
	end

	assign mux_if.fast_edge     = (fast_sync_r[2] ^ fast_sync_r[1]) && fast_en_r; // [RQ1]
	assign mux_if.slow_edge     = (slow_sync_r[2] ^ slow_sync_r[1]) && slow_en_r; // [RQ5]
	assign mux_if.freq_sel      = freq_sel_r;
	assign mux_if.slow_src_fast = trim_reg_r[osc_pkg::TRIM_SLOW_SRC_BIT];

	glitch_free_clock_mux u_clock_mux (
		.sys_clk_in (sys_clk_in),
		.rst_n_in   (rst_n_in),
		.mux_if     (mux_if.mux)
	);

	assign device_clk_out = mux_if.dev_clk;

	// device clock over four: toggle on every second rising edge
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			fosc4_phase_r <= 1'b0;
			fosc4_r       <= 1'b0;
		end else if (mux_if.dev_rise) begin
			fosc4_phase_r <= ~fosc4_phase_r;
			if (fosc4_phase_r) begin
				fosc4_r <= ~fosc4_r; // [RQ8]
			end
		end
	end

	// pin levels in from outside the clock domain
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			first_sync_r  <= 2'h0;
			second_sync_r <= 2'h0;
		end else begin
			first_sync_r  <= {first_sync_r[0], first_osc_pin_in};
			second_sync_r <= {second_sync_r[0], second_osc_pin_in};
		end
	end

	assign port_a_bit_seven_read_out = internal_mode ? first_sync_r[1] : 1'b0;
	assign port_a_bit_six_read_out   = (pin_mode_in == osc_pkg::PIN_MODE_DUAL_IO) ? second_sync_r[1] : 1'b0;

	// pin drivers; external mode leaves both pins to the crystal circuit
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			first_out_r  <= 1'b0;
			first_oe_r   <= 1'b0;
			second_out_r <= 1'b0;
			second_oe_r  <= 1'b0;
		end else begin
			case (pin_mode_in)
				osc_pkg::PIN_MODE_CLKOUT: begin
					first_out_r  <= port_a_bit_seven_data_in; // [RQ8]
					first_oe_r   <= port_a_bit_seven_drive_in;
					second_out_r <= fosc4_r; // [RQ8]
					second_oe_r  <= 1'b1;
				end
				osc_pkg::PIN_MODE_DUAL_IO: begin
					first_out_r  <= port_a_bit_seven_data_in; // [RQ9]
					first_oe_r   <= port_a_bit_seven_drive_in;
					second_out_r <= port_a_bit_six_data_in; // [RQ9]
					second_oe_r  <= port_a_bit_six_drive_in;
				end
				default: begin
					first_out_r  <= 1'b0;
					first_oe_r   <= 1'b0;
					second_out_r <= 1'b0;
					second_oe_r  <= 1'b0;
				end
			endcase
		end
	end

	assign first_osc_pin_out     = first_out_r;
	assign first_osc_pin_oe_out  = first_oe_r;
	assign second_osc_pin_out    = second_out_r;
	assign second_osc_pin_oe_out = second_oe_r;

	// cycles since the last trim write while the code is still walking
	logic [15:0] settle_wait_r;

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in || trim_wr) begin
			settle_wait_r <= 16'h0000;
		end else if (trim_cur_r != trim_reg_r[osc_pkg::TRIM_FIELD_MSB:0] && settle_wait_r != 16'hffff) begin
			settle_wait_r <= 16'(settle_wait_r + 16'h0001);
		end
	end

	default clocking top_cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);

	AST_FAST_RUNS: assert property (freq_sel_r != osc_pkg::FREQ_SEL_31K |=> fast_osc_en_out) // [RQ3]
		else $error("fast oscillator off with a fast setting selected");
	AST_SLOW_SOURCE: assert property (freq_sel_r == osc_pkg::FREQ_SEL_31K && !trim_reg_r[osc_pkg::TRIM_SLOW_SRC_BIT]
		&& !mux_if.on_fast |=> slow_rc_en_out && !fast_osc_en_out) // [RQ4]
		else $error("slow source selection did not switch oscillators");
	AST_KEEP_OLD_FAST: assert property (mux_if.on_fast |=> fast_osc_en_out) // [RQ15]
		else $error("fast oscillator stopped while the mux still runs on it");
	AST_KEEP_OLD_SLOW: assert property (!mux_if.on_fast |=> slow_rc_en_out) // [RQ15]
		else $error("slow oscillator stopped while the mux still runs on it");
	AST_EXTERNAL_RELEASE: assert property (!internal_mode |=> !first_osc_pin_oe_out && !second_osc_pin_oe_out) // [RQ9]
		else $error("oscillator pins driven outside internal pin modes");
	AST_TRIM_HOLD: assert property (trim_cur_r == trim_reg_r[osc_pkg::TRIM_FIELD_MSB:0] && !trim_wr
		|=> $stable(trim_cur_r)) // [RQ10]
		else $error("trim code moved away from its target");
	AST_TRIM_READBACK: assert property (reg_rd_in && reg_addr_in == osc_pkg::TRIM_ADDR
		|=> reg_rdata_out == $past(trim_reg_r)) // [RQ10]
		else $error("trim register read back the wrong value");
	AST_SLOW_FEATURES: assert property (pwrt_en_in || fail_safe_en_in || watchdog_en_in || two_speed_en_in
		|=> slow_rc_en_out) // [RQ6]
		else $error("slow oscillator off while a dependent feature is on");
	AST_CLKOUT_PINS: assert property (pin_mode_in == osc_pkg::PIN_MODE_CLKOUT |=> second_osc_pin_oe_out
		&& second_osc_pin_out == $past(fosc4_r) && first_osc_pin_oe_out == $past(port_a_bit_seven_drive_in)) // [RQ8]
		else $error("clock-out pin mode drives the wrong values");
	AST_DUAL_IO_PINS: assert property (pin_mode_in == osc_pkg::PIN_MODE_DUAL_IO |=>
		second_osc_pin_out == $past(port_a_bit_six_data_in)
		&& second_osc_pin_oe_out == $past(port_a_bit_six_drive_in)
		&& first_osc_pin_out == $past(port_a_bit_seven_data_in)) // [RQ9]
		else $error("dual port pin mode drives the wrong values");
	AST_TRIM_SINGLE_STEP: assert property ($changed(trim_cur_r) |->
		(5'(trim_cur_r - $past(trim_cur_r)) == 5'h01) || (5'($past(trim_cur_r) - trim_cur_r) == 5'h01)) // [RQ11]
		else $error("trim code jumped more than one level");
	AST_TRIM_SETTLES: assert property (settle_wait_r <= SETTLE_LIMIT) // [RQ11]
		else $error("trim code failed to settle within the settle time");
	AST_PLL_GATE: assert property (!internal_mode |=> !pll_enable_out) // [RQ14]
		else $error("PLL enabled outside internal oscillator modes");
	AST_READ_ONE_CYCLE: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00) // [RQ12]
		else $error("read data present without a read strobe");

	COV_TRIM_WALK: cover property (trim_wr ##1 $changed(trim_cur_r));
	COV_FOSC4_OUT: cover property (pin_mode_in == osc_pkg::PIN_MODE_CLKOUT && $rose(second_osc_pin_out));

endmodule // internal_oscillator_block

// ===== core/osc_pkg.sv
// Overview of operation
// RQ1 - fast oscillator gives 8 MHz, usable directly as device clock and feeding postscaler
// RQ2 - postscaler divides the fast oscillator to give 31 kHz up to 4 MHz
// RQ3 - fast oscillator runs whenever the selection is 125 kHz through 8 MHz
// RQ4 - at 31 kHz, trim bit 7 picks postscaled fast oscillator or slow RC
// RQ5 - slow RC gives nominal 31 kHz and runs whenever it is the clock source
// RQ6 - slow RC also runs for power-up timer, clock monitor, watchdog or two-speed start
// RQ7 - control register frequency field picks fast direct, slow direct or postscaler output
// RQ8 - clock-out mode: second pin drives device clock over four, first pin is port bit
// RQ9 - dual-I/O mode: first pin is port bit seven, second pin port bit six
// RQ10 - five-bit trim field in low trim bits, software writable, shifts fast oscillator
// RQ11 - after a trim write the frequency walks over and settles within 1 ms, no stall
// RQ12 - no flag or status bit reports that the trim shift has finished
// RQ13 - trim writes touch only the fast oscillator, slow RC stays independent
// RQ14 - trim bit 6 enables the PLL while an internal oscillator mode is in use
// RQ15 - source or postscaler changes switch the device clock without glitches or runts
package osc_pkg;

	localparam int CLK_FREQ_HZ         = 20_000_000;
	localparam int TRIM_SETTLE_TIME_US = 1000;
	// longest time, rounded down to whole cycles
	localparam int TRIM_SETTLE_CYCLES  = (TRIM_SETTLE_TIME_US * (CLK_FREQ_HZ / 1_000_000));
	localparam int TRIM_LEVELS         = 32;

	localparam logic [3:0] CTRL_ADDR = 4'h0;
	localparam logic [3:0] TRIM_ADDR = 4'h1;

	localparam int CTRL_FREQ_LSB     = 4;
	localparam int CTRL_ON_FAST_BIT  = 3;
	localparam int CTRL_SLOW_RUN_BIT = 2;
	localparam int TRIM_SLOW_SRC_BIT = 7;
	localparam int TRIM_PLL_BIT      = 6;
	localparam int TRIM_FIELD_MSB    = 4;

	localparam logic [2:0] FREQ_SEL_31K    = 3'h0;
	localparam logic [2:0] FREQ_SEL_RESET  = 3'h4;
	localparam logic [7:0] TRIM_RESET      = 8'h00;
	localparam logic [7:0] TRIM_WRITE_MASK = 8'hdf;

	typedef enum logic [1:0] {
		PIN_MODE_EXTERNAL = 2'b00,
		PIN_MODE_CLKOUT   = 2'b01,
		PIN_MODE_DUAL_IO  = 2'b10
	} pin_mode_t;

	typedef enum logic {
		MUX_RUN = 1'b0,
		MUX_ARM = 1'b1
	} mux_state_t;

endpackage

// ===== core/clk_mux_if.sv
interface clk_mux_if;
	logic       fast_edge;
	logic       slow_edge;
	logic [2:0] freq_sel;
	logic       slow_src_fast;
	logic       dev_clk;
	logic       dev_rise;
	logic       on_fast;

	modport ctrl (output fast_edge, output slow_edge, output freq_sel, output slow_src_fast,
		input dev_clk, input dev_rise, input on_fast);
	modport mux (input fast_edge, input slow_edge, input freq_sel, input slow_src_fast,
		output dev_clk, output dev_rise, output on_fast);
endinterface

// ===== core/glitch_free_clock_mux.sv
module glitch_free_clock_mux (
	input wire logic  sys_clk_in,   // system clock
	input wire logic  rst_n_in,     // synchronous reset, active low
	clk_mux_if.mux    mux_if        // edges in, device clock out
);

	osc_pkg::mux_state_t state_r;
	logic [2:0]          sel_r;
	logic                src_fast_r;
	logic [7:0]          cnt_r;
	logic                clk_r;
	logic                clk_nxt;
	logic                rise_r;
	logic                req_fast;
	logic                change;
	logic                src_tick;

	// half period of the postscaled clock, in fast oscillator edges, minus one
	function automatic logic [7:0] half_period_mask(input logic [2:0] sel);
		half_period_mask = (sel == osc_pkg::FREQ_SEL_31K) ? 8'hff : 8'(8'h7f >> sel);
	endfunction

	assign req_fast = (mux_if.freq_sel != osc_pkg::FREQ_SEL_31K) || mux_if.slow_src_fast;
	assign change   = (sel_r != mux_if.freq_sel) || (src_fast_r != req_fast);
	assign src_tick = src_fast_r ?
		(mux_if.fast_edge && ((cnt_r & half_period_mask(sel_r)) == half_period_mask(sel_r))) : // [RQ1] [RQ2]
		mux_if.slow_edge; // [RQ5]

	always_comb begin
		clk_nxt = clk_r;
		if (state_r == osc_pkg::MUX_RUN && !(change && !clk_r) && src_tick) begin
			clk_nxt = ~clk_r;
		end
	end

	// a change is taken only while the clock is low; the new source then gets a full half period
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			state_r    <= osc_pkg::MUX_ARM;
			sel_r      <= osc_pkg::FREQ_SEL_RESET;
			src_fast_r <= 1'b1;
			cnt_r      <= 8'h00;
		end else begin
			case (state_r)
				osc_pkg::MUX_RUN: begin
					if (change && !clk_r) begin // [RQ15]
						state_r    <= osc_pkg::MUX_ARM;
						sel_r      <= mux_if.freq_sel; // [RQ7]
						src_fast_r <= req_fast; // [RQ4]
						cnt_r      <= 8'h00;
					end else if (mux_if.fast_edge) begin
						cnt_r <= 8'(cnt_r + 8'h01);
					end
				end
				osc_pkg::MUX_ARM: begin
					if (src_tick) begin
						state_r <= osc_pkg::MUX_RUN; // [RQ15]
					end
					if (mux_if.fast_edge) begin
						cnt_r <= 8'(cnt_r + 8'h01);
					end
				end
				default: begin
					state_r <= osc_pkg::MUX_ARM;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			clk_r  <= 1'b0;
			rise_r <= 1'b0;
		end else begin
			clk_r  <= clk_nxt;
			rise_r <= clk_nxt & ~clk_r;
		end
	end

	assign mux_if.dev_clk  = clk_r;
	assign mux_if.dev_rise = rise_r;
	assign mux_if.on_fast  = src_fast_r;

	default clocking mux_cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);

	// direct 8 MHz sampled at 20 MHz may give one-cycle phases; every divided or slow phase spans two
	AST_NO_RUNT_HIGH: assert property ($rose(clk_r) && !(src_fast_r && sel_r == 3'h7) |=> clk_r) // [RQ15]
		else $error("divided device clock high phase shorter than two cycles");
	AST_NO_TOGGLE_IN_SWITCH: assert property (state_r == osc_pkg::MUX_ARM |=> $stable(clk_r)) // [RQ15]
		else $error("device clock moved while arming a new source");
	AST_DIRECT_FAST: assert property (state_r == osc_pkg::MUX_RUN && src_fast_r && sel_r == 3'h7
		&& !change && mux_if.fast_edge |=> clk_r != $past(clk_r)) // [RQ1]
		else $error("direct fast clock missed an oscillator edge");

	COV_SWITCH_SLOW: cover property (state_r == osc_pkg::MUX_ARM && !src_fast_r ##[1:40] state_r == osc_pkg::MUX_RUN);
	COV_POSTSCALE: cover property (src_fast_r && sel_r == 3'h1 && $rose(clk_r));

endmodule // glitch_free_clock_mux

// ===== sim/osc_source_model.sv
module osc_source_model (
	input  wire logic fast_en_in,   // fast oscillator run enable
	input  wire logic slow_en_in,   // slow RC run enable
	output logic      fast_clk_out, // fast oscillator waveform
	output logic      slow_clk_out  // slow RC waveform
);
	timeunit 1ns;
	timeprecision 1ps;

	initial fast_clk_out = 1'b0;
	initial slow_clk_out = 1'b0;

	// 8 MHz, stands low while not enabled
	always begin
		#62.5;
		fast_clk_out = fast_en_in ? ~fast_clk_out : 1'b0;
	end

	// nominal 31 kHz, free of any trim influence
	always begin
		#16000;
		slow_clk_out = slow_en_in ? ~slow_clk_out : 1'b0;
	end
endmodule // osc_source_model

// ===== sim/internal_oscillator_block_bench.sv
module internal_oscillator_block_bench;
	timeunit 1ns;
	timeprecision 1ps;

	logic       clk, rst_n, wr, rd, f_clk, s_clk, fast_en, slow_en, pll, dclk;
	logic       p1_out, p1_oe, p2_out, p2_oe, p7_rd, p6_rd, d7, e7, d6, e6, x7, x6;
	logic [3:0] addr, feat;
	logic [7:0] wdata, rdata, got;
	logic [4:0] trim;
	logic [1:0] mode;
	wire        p1_pin, p2_pin;
	int         num_errors = 0;
	int         num_checks = 0;
	int         cycles = 0;
	int         hi_cnt = 0;
	int         min_hi = 2;
	int         n;

	// pin level resolved from the block's drive and the outside world
	assign p1_pin = p1_oe ? p1_out : x7;
	assign p2_pin = p2_oe ? p2_out : x6;

	always #25 clk = ~clk;

	internal_oscillator_block #(.TRIM_SETTLE_CYCLES(64)) dut_u (
		.sys_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .fast_osc_clk_in(f_clk),
		.slow_rc_clk_in(s_clk), .fast_osc_en_out(fast_en), .slow_rc_en_out(slow_en),
		.trim_field_out(trim), .pll_enable_out(pll), .pwrt_en_in(feat[0]), .fail_safe_en_in(feat[1]),
		.watchdog_en_in(feat[2]), .two_speed_en_in(feat[3]), .pin_mode_in(mode), .device_clk_out(dclk),
		.first_osc_pin_in(p1_pin), .first_osc_pin_out(p1_out), .first_osc_pin_oe_out(p1_oe),
		.second_osc_pin_in(p2_pin), .second_osc_pin_out(p2_out), .second_osc_pin_oe_out(p2_oe),
		.port_a_bit_seven_data_in(d7), .port_a_bit_seven_drive_in(e7), .port_a_bit_seven_read_out(p7_rd),
		.port_a_bit_six_data_in(d6), .port_a_bit_six_drive_in(e6), .port_a_bit_six_read_out(p6_rd)
	);

	osc_source_model src_u (
		.fast_en_in(fast_en), .slow_en_in(slow_en), .fast_clk_out(f_clk), .slow_clk_out(s_clk)
	);

	task automatic complete_run();
		if (num_errors == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic check_value(input logic [7:0] g, input logic [7:0] e, input string what);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %0t %s got %h exp %h", $time, what, g, e);
		end
	endtask

	task automatic check_count(input int g, input int lo, input int hi, input string what);
		num_checks++;
		if (g < lo || g > hi) begin
			num_errors++;
			$display("BAD %0t %s got %0d exp %0d..%0d", $time, what, g, lo, hi);
		end
	endtask

	task automatic step(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		step(2);
	endtask

	task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	// counts rising edges of the device clock or of the second pin
	task automatic measure(input int ncyc, input bit pin2, output int cnt);
		logic prev, cur;
		cnt = 0;
		prev = pin2 ? p2_out : dclk;
		repeat (ncyc) begin
			@(posedge clk);
			#1;
			cur = pin2 ? p2_out : dclk;
			if (cur === 1'b1 && prev === 1'b0)
				cnt++;
			prev = cur;
		end
	endtask

	// every high phase of the device clock must be a full pulse
	always @(negedge clk) begin
		if (!rst_n)
			hi_cnt = 0;
		else if (dclk === 1'b1)
			hi_cnt++;
		else begin
			if (hi_cnt > 0)
				check_count(hi_cnt, min_hi, 400, "device clock high phase");
			hi_cnt = 0;
		end
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 95000) begin
			num_errors++;
			complete_run();
		end
	end

	initial begin
		clk = 1'b0; rst_n = 1'b0; wr = 1'b0; rd = 1'b0; addr = 4'h0; wdata = 8'h00; feat = 4'h0;
		mode = 2'b00; d7 = 1'b0; e7 = 1'b0; d6 = 1'b0; e6 = 1'b0; x7 = 1'b0; x6 = 1'b0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		step(1);
		reg_read(4'h0, got);
		check_value(got & 8'hf3, 8'h40, "control after reset");
		reg_read(4'h1, got);
		check_value(got, 8'h00, "trim after reset");
		check_value({6'h0, fast_en, slow_en}, 8'h02, "enables after reset");
		reg_write(4'h5, 8'hff);
		reg_read(4'h5, got);
		check_value(got, 8'h00, "unmapped read");
		reg_write(4'h1, 8'h1f);
		check_value({7'h0, trim < 5'h1f}, 8'h01, "trim jumps at once");
		step(64);
		check_value({3'h0, trim}, 8'h1f, "trim not settled");
		reg_read(4'h1, got);
		check_value(got, 8'h1f, "trim readback");
		reg_read(4'h0, got);
		check_value(got & 8'hf3, 8'h40, "control changed by trim");
		check_value({6'h0, fast_en, slow_en}, 8'h02, "slow RC touched by trim");
		reg_write(4'h1, 8'hff);
		reg_read(4'h1, got);
		check_value(got, 8'hdf, "trim bit five");
		reg_write(4'h1, 8'h00);
		for (int s = 1; s < 8; s++) begin
			if (s == 7)
				min_hi = 1;
			reg_write(4'h0, 8'(s << 4));
			check_value({6'h0, fast_en, slow_en}, 8'h02, "fast source enables");
			step(800);
			measure(2000, 1'b0, n);
			check_count(n, (800 >> (7 - s)) - 2, (800 >> (7 - s)) + 2, "device clock rate");
		end
		reg_write(4'h1, 8'h80);
		reg_write(4'h0, 8'h00);
		check_value({6'h0, fast_en, slow_en}, 8'h02, "31k from fast enables");
		step(800);
		min_hi = 2;
		measure(16000, 1'b0, n);
		check_count(n, 23, 27, "31k postscaled rate");
		reg_write(4'h1, 8'h00);
		step(800);
		check_value({6'h0, fast_en, slow_en}, 8'h01, "31k from slow RC enables");
		measure(16000, 1'b0, n);
		check_count(n, 23, 27, "slow RC rate");
		reg_read(4'h0, got);
		check_value(got & 8'hf7, 8'h04, "slow RC status");
		reg_write(4'h0, 8'h40);
		step(800);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			feat <= 4'(1 << i);
			step(2);
			check_value({7'h0, slow_en}, 8'h01, "feature slow RC");
		end
		@(posedge clk);
		feat <= 4'h0;
		step(2);
		check_value({7'h0, slow_en}, 8'h00, "slow RC left on");
		reg_write(4'h1, 8'h40);
		for (int m = 0; m < 3; m++) begin
			@(posedge clk);
			mode <= 2'(m);
			step(2);
			check_value({7'h0, pll}, {7'h0, m != 0}, "pll enable");
		end
		@(posedge clk);
		mode <= 2'b01;
		d7 <= 1'b1;
		e7 <= 1'b1;
		x6 <= 1'b1;
		step(3);
		check_value({4'h0, p1_out, p1_oe, p2_oe, p6_rd}, 8'h0e, "clock-out mode pins");
		measure(2000, 1'b1, n);
		check_count(n, 23, 27, "quarter clock on second pin");
		@(posedge clk);
		e7 <= 1'b0;
		x7 <= 1'b1;
		step(4);
		check_value({7'h0, p7_rd}, 8'h01, "port bit seven input");
		@(posedge clk);
		mode <= 2'b10;
		d6 <= 1'b1;
		e6 <= 1'b1;
		step(3);
		check_value({4'h0, p1_oe, p2_out, p2_oe, p7_rd}, 8'h07, "dual-I/O mode pins");
		@(posedge clk);
		e6 <= 1'b0;
		step(4);
		check_value({7'h0, p6_rd}, 8'h01, "port bit six input");
		@(posedge clk);
		mode <= 2'b00;
		step(3);
		check_value({4'h0, p1_oe, p2_oe, p7_rd, p6_rd}, 8'h00, "pins released");
		complete_run();
	end
endmodule // internal_oscillator_block_bench
